// ### rtl/isa_regs.svh
// register map, field positions, reset values and vectors of the arbiter
// How it works
// - pending non-maskable requests ignore the global enable and outrank all
// - any pending request drives the standby release output
// - non-maskable sources are watchdog overflow and key-return edge only
// - five maskable sources, each gated by its own mask flag
// - seven sources in total across both classes
// - maskable order: watchdog, timer a, timer b, low voltage, eeprom
// - key-return edge raises the external non-maskable request, vector 0002H
// - watchdog overflow in mode 2 raises non-maskable request, vector 0004H
// - watchdog overflow in interval mode raises maskable priority 0 request
// - watchdog mode selects at most one interrupt form, never both
// - timer a vectors through 0006H, timer b through 0008H
// - low voltage vectors through 000AH, eeprom done through 000CH
// - key-return requests only while in stop mode
// - falling edge on any of four key-return pins triggers the request
// - no mask flag can suppress the key-return request
// - flags set by event or software, cleared by ack, software, reset
// - mask 0 enables, 1 disables; reset sets all mask bits to ones
// - acknowledge clears global enable and signals a status word push
`ifndef ISA_REGS_SVH
`define ISA_REGS_SVH

`define ISA_ADDR_REQ 8'h00
`define ISA_ADDR_MASK 8'h04
`define ISA_ADDR_CTRL 8'h08
`define ISA_ADDR_NMI 8'h0c

`define ISA_REQ_RESET 5'h00
`define ISA_MASK_RESET 8'hff
`define ISA_KR_IDLE 4'hf

`define ISA_CTRL_IE_BIT 0
`define ISA_CTRL_MODE_LO 1
`define ISA_CTRL_MODE_HI 2
`define ISA_NMI_KR_BIT 0
`define ISA_NMI_WDT_BIT 1

`define ISA_WDT_MODE_STOP 2'h0
`define ISA_WDT_MODE_INTERVAL 2'h1
`define ISA_WDT_MODE_NMI 2'h2
`define ISA_WDT_MODE_RESET 2'h3

`define ISA_IDX_KR 3'h0
`define ISA_IDX_WDT_NMI 3'h1
`define ISA_IDX_MASK_BASE 3'h2
`define ISA_IDX_NONE 3'h7

`define ISA_VEC_KR 16'h0002
`define ISA_VEC_WDT 16'h0004
`define ISA_VEC_TIMER_A 16'h0006
`define ISA_VEC_TIMER_B 16'h0008
`define ISA_VEC_LOW_VOLTAGE 16'h000a
`define ISA_VEC_EEPROM 16'h000c
`define ISA_VEC_NONE 16'h0000

`endif

// ### rtl/isa_pkg.sv
// shared types of the interrupt source arbiter
package isa_pkg;
    typedef logic [2:0] isa_src_t;
    typedef logic [1:0] isa_wdt_mode_t;
    typedef logic [15:0] isa_vector_t;
endpackage : isa_pkg

// ### rtl/isa_vec_rom.sv
// vector table lookup with a registered read port
`timescale 1ns/1ps
`include "isa_regs.svh"
module isa_vec_rom (
    input wire logic hclk,
    input wire logic hresetn,
    input wire isa_pkg::isa_src_t idx,
    output isa_pkg::isa_vector_t vector
);
    isa_pkg::isa_vector_t vector_d;

    always_comb begin
        case (idx)
            `ISA_IDX_KR: vector_d = `ISA_VEC_KR;
            `ISA_IDX_WDT_NMI: vector_d = `ISA_VEC_WDT;
            3'h2: vector_d = `ISA_VEC_WDT;
            3'h3: vector_d = `ISA_VEC_TIMER_A;
            3'h4: vector_d = `ISA_VEC_TIMER_B;
            3'h5: vector_d = `ISA_VEC_LOW_VOLTAGE;
            3'h6: vector_d = `ISA_VEC_EEPROM;
            default: vector_d = `ISA_VEC_NONE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector <= `ISA_VEC_NONE;
        end else begin
            vector <= vector_d;
        end
    end
endmodule : isa_vec_rom

// ### rtl/isa_arbiter.sv
// interrupt source collection, arbitration and ahb-lite register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "isa_regs.svh"
module isa_arbiter #(
    parameter int NUM_KR = 4,
    parameter int NUM_MASKABLE = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [NUM_KR-1:0] key_return_input,
    input wire logic stop_mode,
    input wire logic watchdog_overflow_irq,
    input wire logic timer_a_match_irq,
    input wire logic timer_b_match_irq,
    input wire logic low_voltage_irq,
    input wire logic eeprom_write_done_irq,
    input wire logic irq_ack,
    output logic irq_req,
    output logic irq_nmi,
    output isa_pkg::isa_vector_t irq_vector,
    output logic standby_release,
    output logic psw_push
);
    // ---------------- bus slave ----------------
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q;
    logic hresp_q;
    logic addr_phase;

    // ---------------- flag state ----------------
    logic [NUM_MASKABLE-1:0] irq_request_flags_q, irq_request_flags_d;
    logic [7:0] irq_mask_flags_q, irq_mask_flags_d;
    logic irq_global_enable_q, irq_global_enable_d;
    isa_pkg::isa_wdt_mode_t wdt_mode_q, wdt_mode_d;
    logic kr_nmi_q, kr_nmi_d;
    logic wdt_nmi_q, wdt_nmi_d;
    logic [NUM_KR-1:0] kr_prev_q, kr_prev_d;

    // ---------------- core side outputs ----------------
    logic irq_req_q, irq_req_d;
    logic irq_nmi_q, irq_nmi_d;
    isa_pkg::isa_src_t irq_idx_q, irq_idx_d;
    logic standby_q, standby_d;
    logic psw_push_q, psw_push_d;

    logic kr_fall;
    logic wdt_nmi_set;
    logic [NUM_MASKABLE-1:0] src_set;
    logic [NUM_MASKABLE-1:0] pending;
    logic ack_take;
    isa_pkg::isa_src_t sel_idx;

    // lowest set bit wins, so bit 0 is the highest priority
    function automatic isa_pkg::isa_src_t first_set(
        input logic [NUM_MASKABLE-1:0] v
    );
        isa_pkg::isa_src_t r;
        r = `ISA_IDX_NONE;
        for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_set

    assign addr_phase = hsel & hready & htrans[1];

    // read data is captured at the address phase edge, so the slave
    // answers with zero wait states and hrdata comes from a flop
    always_comb begin
        wr_pend_d = addr_phase & hwrite;
        wr_addr_d = addr_phase ? haddr[7:0] : wr_addr_q;
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite) begin
            hrdata_d = 32'h0000_0000;
            case (haddr[7:0])
                `ISA_ADDR_REQ: hrdata_d[NUM_MASKABLE-1:0] =
                    irq_request_flags_q;
                `ISA_ADDR_MASK: hrdata_d[7:0] = irq_mask_flags_q;
                `ISA_ADDR_CTRL: begin
                    hrdata_d[`ISA_CTRL_IE_BIT] = irq_global_enable_q;
                    hrdata_d[`ISA_CTRL_MODE_HI:`ISA_CTRL_MODE_LO] =
                        wdt_mode_q;
                end
                `ISA_ADDR_NMI: begin
                    hrdata_d[`ISA_NMI_KR_BIT] = kr_nmi_q;
                    hrdata_d[`ISA_NMI_WDT_BIT] = wdt_nmi_q;
                end
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    // ---------------- source capture ----------------
    // pins idle high; only a high-to-low step counts, held low is ignored
    assign kr_fall = stop_mode &
        (|(kr_prev_q & ~key_return_input));
    assign wdt_nmi_set = watchdog_overflow_irq &
        (wdt_mode_q == `ISA_WDT_MODE_NMI);
    assign src_set = {eeprom_write_done_irq,
                      low_voltage_irq,
                      timer_b_match_irq,
                      timer_a_match_irq,
                      watchdog_overflow_irq &
                          (wdt_mode_q == `ISA_WDT_MODE_INTERVAL)};
    assign ack_take = irq_ack & irq_req_q;

    always_comb begin
        kr_prev_d = key_return_input;
        irq_request_flags_d = irq_request_flags_q;
        irq_mask_flags_d = irq_mask_flags_q;
        irq_global_enable_d = irq_global_enable_q;
        wdt_mode_d = wdt_mode_q;
        kr_nmi_d = kr_nmi_q;
        wdt_nmi_d = wdt_nmi_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                `ISA_ADDR_REQ: irq_request_flags_d =
                    hwdata[NUM_MASKABLE-1:0];
                `ISA_ADDR_MASK: irq_mask_flags_d = hwdata[7:0];
                `ISA_ADDR_CTRL: begin
                    irq_global_enable_d = hwdata[`ISA_CTRL_IE_BIT];
                    wdt_mode_d =
                        hwdata[`ISA_CTRL_MODE_HI:`ISA_CTRL_MODE_LO];
                end
                `ISA_ADDR_NMI: begin
                    // write one to clear a pending non-maskable flag
                    if (hwdata[`ISA_NMI_KR_BIT]) begin
                        kr_nmi_d = 1'b0;
                    end
                    if (hwdata[`ISA_NMI_WDT_BIT]) begin
                        wdt_nmi_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (ack_take) begin
            irq_global_enable_d = 1'b0;
            case (irq_idx_q)
                `ISA_IDX_KR: kr_nmi_d = 1'b0;
                `ISA_IDX_WDT_NMI: wdt_nmi_d = 1'b0;
                `ISA_IDX_NONE: ;
                default: irq_request_flags_d[irq_idx_q -
                    `ISA_IDX_MASK_BASE] = 1'b0;
            endcase
        end
        // hardware set wins over any clear in the same cycle
        irq_request_flags_d = irq_request_flags_d | src_set;
        kr_nmi_d = kr_nmi_d | kr_fall;
        wdt_nmi_d = wdt_nmi_d | wdt_nmi_set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kr_prev_q <= `ISA_KR_IDLE;
            irq_request_flags_q <= `ISA_REQ_RESET;
            irq_mask_flags_q <= `ISA_MASK_RESET;
            irq_global_enable_q <= 1'b0;
            wdt_mode_q <= `ISA_WDT_MODE_STOP;
            kr_nmi_q <= 1'b0;
            wdt_nmi_q <= 1'b0;
        end else begin
            kr_prev_q <= kr_prev_d;
            irq_request_flags_q <= irq_request_flags_d;
            irq_mask_flags_q <= irq_mask_flags_d;
            irq_global_enable_q <= irq_global_enable_d;
            wdt_mode_q <= wdt_mode_d;
            kr_nmi_q <= kr_nmi_d;
            wdt_nmi_q <= wdt_nmi_d;
        end
    end

    // ---------------- arbitration ----------------
    // seven sources: two non-maskable ahead of five maskable
    assign pending = irq_request_flags_q &
        ~irq_mask_flags_q[NUM_MASKABLE-1:0];

    always_comb begin
        if (kr_nmi_q) begin
            sel_idx = `ISA_IDX_KR;
        end else if (wdt_nmi_q) begin
            sel_idx = `ISA_IDX_WDT_NMI;
        end else if (irq_global_enable_q && (|pending)) begin
            sel_idx = 3'(first_set(pending) +
                `ISA_IDX_MASK_BASE);
        end else begin
            sel_idx = `ISA_IDX_NONE;
        end
    end

    // an acknowledged request is withdrawn for one cycle so the core
    // cannot take the stale presentation twice
    always_comb begin
        irq_idx_d = ack_take ? `ISA_IDX_NONE : sel_idx;
        irq_req_d = !ack_take && (sel_idx != `ISA_IDX_NONE);
        irq_nmi_d = !ack_take && (kr_nmi_q || wdt_nmi_q);
        standby_d = kr_nmi_q | wdt_nmi_q | (|pending);
        psw_push_d = ack_take;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_idx_q <= `ISA_IDX_NONE;
            irq_req_q <= 1'b0;
            irq_nmi_q <= 1'b0;
            standby_q <= 1'b0;
            psw_push_q <= 1'b0;
        end else begin
            irq_idx_q <= irq_idx_d;
            irq_req_q <= irq_req_d;
            irq_nmi_q <= irq_nmi_d;
            standby_q <= standby_d;
            psw_push_q <= psw_push_d;
        end
    end

    // vector is registered in the table, aligned with irq_req
    isa_vec_rom u_vec_rom (
        .hclk(hclk),
        .hresetn(hresetn),
        .idx(irq_idx_d),
        .vector(irq_vector)
    );

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = hresp_q;
    assign irq_req = irq_req_q;
    assign irq_nmi = irq_nmi_q;
    assign standby_release = standby_q;
    assign psw_push = psw_push_q;
endmodule : isa_arbiter

// ### tb/isa_core_model.sv
// behavioural cpu core that takes requests and pushes its status word
`timescale 1ns/1ps
module isa_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_req,
    input wire isa_pkg::isa_vector_t irq_vector,
    input wire logic psw_push,
    input wire logic [3:0] ack_delay,
    output logic irq_ack
);
    isa_pkg::isa_vector_t taken[$];
    int pushes;
    int wait_n;
    // ack_delay lets the bench play a prompt or a slow core
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ack <= 1'b0;
            wait_n = 0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
        end else if (irq_req && wait_n >= ack_delay) begin
            irq_ack <= 1'b1;
            taken.push_back(irq_vector);
            wait_n = 0;
        end else if (irq_req) begin
            wait_n++;
        end
        if (hresetn && psw_push)
            pushes++;
    end
endmodule : isa_core_model

// ### tb/isa_arbiter_properties.sv
// concurrent checks on the arbiter's ports
`timescale 1ns/1ps
module isa_arbiter_properties #(
    parameter int NUM_KR = 4,
    parameter int NUM_MASKABLE = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NUM_KR-1:0] key_return_input,
    input wire logic stop_mode,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic irq_nmi,
    input wire isa_pkg::isa_vector_t irq_vector,
    input wire logic standby_release,
    input wire logic psw_push
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_release;
        irq_req |-> standby_release;
    endproperty
    a_release: assert property (p_release) else $error("no release");
    property p_nmi_vec;
        irq_req && irq_nmi |-> irq_vector inside {16'h0002, 16'h0004};
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vec");
    property p_mask_vec;
        irq_req && !irq_nmi |-> irq_vector inside
            {16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c};
    endproperty
    a_mask_vec: assert property (p_mask_vec) else $error("vec");
    property p_ack_push;
        irq_req && irq_ack |=> psw_push && !irq_req;
    endproperty
    a_ack_push: assert property (p_ack_push) else $error("no push");
    property p_push_once;
        psw_push |=> !psw_push;
    endproperty
    a_push_once: assert property (p_push_once) else $error("push");
    property p_push_cause;
        psw_push |-> $past(irq_req && irq_ack);
    endproperty
    a_push_cause: assert property (p_push_cause) else $error("cause");
    property p_ie_cleared;
        psw_push |-> ##1 (!irq_req || irq_nmi);
    endproperty
    a_ie_cleared: assert property (p_ie_cleared) else $error("ie");
    property p_idle_vec;
        !irq_req |-> irq_vector == 16'h0000 && !irq_nmi;
    endproperty
    a_idle_vec: assert property (p_idle_vec) else $error("idle");
    // ack is excluded because an acknowledge withdraws irq_req for one cycle
    property p_kr;
        stop_mode && |($past(key_return_input) & ~key_return_input)
            && !irq_ack ##1 !irq_ack |-> ##1 irq_req && irq_nmi
            && irq_vector == 16'h0002;
    endproperty
    a_kr: assert property (p_kr) else $error("key");
endmodule : isa_arbiter_properties

bind isa_arbiter isa_arbiter_properties #(
    .NUM_KR(NUM_KR), .NUM_MASKABLE(NUM_MASKABLE)
) u_props (.hclk, .hresetn, .key_return_input, .stop_mode, .irq_ack,
    .irq_req, .irq_nmi, .irq_vector, .standby_release, .psw_push);

// ### tb/tb.sv
// self-checking bench of the interrupt source arbiter
`timescale 1ns/1ps
module tb;
    logic hclk, hresetn, hsel, hwrite, hresp, stop_mode;
    logic irq_ack, irq_req, irq_nmi, standby_release, psw_push;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, k;
    logic [3:0] key_return_input, ack_delay;
    logic [4:0] src, s;
    wire logic hready;
    isa_pkg::isa_vector_t irq_vector;
    isa_pkg::isa_vector_t exp_q[$];
    isa_pkg::isa_vector_t pv[5] = '{16'h4, 16'h6, 16'h8, 16'ha, 16'hc};
    logic [31:0] rv[5] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0};
    int mismatches;
    int checked;
    isa_arbiter dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp,
        .key_return_input, .stop_mode, .watchdog_overflow_irq(src[0]),
        .timer_a_match_irq(src[1]), .timer_b_match_irq(src[2]),
        .low_voltage_irq(src[3]), .eeprom_write_done_irq(src[4]),
        .irq_ack, .irq_req, .irq_nmi, .irq_vector, .standby_release,
        .psw_push);
    isa_core_model core (.hclk, .hresetn, .irq_req, .irq_vector,
        .psw_push, .ack_delay, .irq_ack);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask : bus
    task automatic fire(input logic [4:0] v);
        src <= v;
        @(posedge hclk);
        src <= 5'h0;
    endtask : fire
    // extra cycles after the last ack catch a spurious second request
    task automatic settle();
        for (int n = 0; n < 200 && core.taken.size() < exp_q.size(); n++)
            @(posedge hclk);
        repeat (8) @(posedge hclk);
        chk(core.taken.size(), exp_q.size());
        foreach (exp_q[i])
            chk(core.taken[i], exp_q[i]);
        chk(core.pushes, core.taken.size());
        core.taken.delete();
        core.pushes = 0;
        exp_q.delete();
        ack_delay <= 4'($urandom_range(7));
    endtask : settle
    task automatic wrap_up();
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        #80000;
        mismatches++;
        wrap_up();
    end
    initial begin
        rd = $urandom(32'h32a79789);
        {hresetn, hsel, hwrite, stop_mode, src, ack_delay} = '0;
        {haddr, hwdata, htrans} = '0;
        key_return_input = 4'hf;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rv[i]) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(rd, rv[i]);
        end
        bus(1'b1, 8'h08, 32'h3);
        fire(5'h1f);
        repeat (3) @(posedge hclk);
        chk(irq_req, 1'b0);
        chk(standby_release, 1'b0);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1f);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        s = 5'($urandom) | 5'h1;
        bus(1'b1, 8'h04, 32'he0);
        for (int i = 0; i < 5; i++)
            if (s[i])
                exp_q.push_back(pv[i]);
        fire(s);
        for (int i = 0; i < exp_q.size(); i++) begin
            for (int n = 0; n < 100 && core.taken.size() <= i; n++)
                @(posedge hclk);
            bus(1'b1, 8'h08, 32'h3);
        end
        settle();
        bus(1'b1, 8'h08, 32'h4);
        bus(1'b1, 8'h04, 32'hff);
        exp_q.push_back(16'h0004);
        fire(5'h01);
        settle();
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        k = 2'($urandom);
        key_return_input[k] <= 1'b0;
        repeat (4) @(posedge hclk);
        chk(irq_req, 1'b0);
        key_return_input <= 4'hf;
        stop_mode <= 1'b1;
        @(posedge hclk);
        key_return_input[k] <= 1'b0;
        exp_q.push_back(16'h0002);
        settle();
        key_return_input <= 4'hf;
        @(posedge hclk);
        key_return_input <= 4'h0;
        exp_q = '{16'h0002, 16'h0004};
        fire(5'h01);
        settle();
        stop_mode <= 1'b0;
        bus(1'b1, 8'h08, 32'h7);
        bus(1'b1, 8'h04, 32'he0);
        fire(5'h01);
        repeat (3) @(posedge hclk);
        chk(irq_req, 1'b0);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h08, 32'h3);
        bus(1'b1, 8'h04, 32'he0);
        exp_q.push_back(16'h0006);
        bus(1'b1, 8'h00, 32'h2);
        repeat (2) @(posedge hclk);
        chk(standby_release, 1'b1);
        settle();
        wrap_up();
    end
endmodule : tb
